// ### common/fctm_pkg.sv
`default_nettype none
package fctm_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned FCTM_REG_COUNT = 10;
  localparam logic [7:0] FCTM_ADDR_FIRST = 8'h42;
  localparam logic [7:0] FCTM_ADDR_LAST = 8'h4b;
  localparam logic [7:0] FCTM_ADDR_BANDPASS_A2_LOW = 8'h42;
  localparam logic [7:0] FCTM_ADDR_BANDPASS_A3_HIGH = 8'h43;
  localparam logic [7:0] FCTM_ADDR_BANDPASS_A3_LOW = 8'h44;
  localparam logic [7:0] FCTM_ADDR_BANDPASS_B1_HIGH = 8'h45;
  localparam logic [7:0] FCTM_ADDR_BANDPASS_B1_LOW = 8'h46;
  localparam logic [7:0] FCTM_ADDR_LOWPASS_A2_HIGH = 8'h47;
  localparam logic [7:0] FCTM_ADDR_LOWPASS_A2_LOW = 8'h48;
  localparam logic [7:0] FCTM_ADDR_LOWPASS_B1_HIGH = 8'h49;
  localparam logic [7:0] FCTM_ADDR_LOWPASS_B1_LOW = 8'h4a;
  localparam logic [7:0] FCTM_ADDR_TEST_AND_DATAPATH = 8'h4b;

  // register index within the bank (address minus first address)
  localparam int unsigned FCTM_IDX_BANDPASS_A2_LOW = 0;
  localparam int unsigned FCTM_IDX_BANDPASS_A3_HIGH = 1;
  localparam int unsigned FCTM_IDX_BANDPASS_A3_LOW = 2;
  localparam int unsigned FCTM_IDX_BANDPASS_B1_HIGH = 3;
  localparam int unsigned FCTM_IDX_BANDPASS_B1_LOW = 4;
  localparam int unsigned FCTM_IDX_LOWPASS_A2_HIGH = 5;
  localparam int unsigned FCTM_IDX_LOWPASS_A2_LOW = 6;
  localparam int unsigned FCTM_IDX_LOWPASS_B1_HIGH = 7;
  localparam int unsigned FCTM_IDX_LOWPASS_B1_LOW = 8;
  localparam int unsigned FCTM_IDX_TEST_AND_DATAPATH = 9;

  // writable bits per register, index 9 down to 0; cleared bits read zero
  localparam logic [9:0][7:0] FCTM_WRITE_MASK = {
    8'hef, 8'hff, 8'h7f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
  };
  localparam logic [7:0] FCTM_RESET_VALUE = 8'h00;
  localparam logic [7:0] FCTM_UNMAPPED_READ = 8'h00;

  // ****************************************************************
  // test and data-path select fields
  // ****************************************************************
  localparam int unsigned FCTM_TEST_SEL_MSB = 7;
  localparam int unsigned FCTM_TEST_SEL_LSB = 5;
  localparam int unsigned FCTM_SAMPLE_FMT_BIT = 3;
  localparam int unsigned FCTM_DP_SEL_MSB = 2;
  localparam int unsigned FCTM_DP_SEL_LSB = 0;

  localparam logic [2:0] FCTM_TEST_GROUND = 3'h0;
  localparam logic [2:0] FCTM_TEST_FRONT_END = 3'h1;
  localparam logic [2:0] FCTM_TEST_OSC_8MHZ = 3'h4;
  localparam logic [2:0] FCTM_TEST_ADC_CLOCK = 3'h5;

  localparam logic [2:0] FCTM_DP_OFF = 3'h0;
  localparam logic [2:0] FCTM_DP_LOWPASS = 3'h1;
  localparam logic [2:0] FCTM_DP_ADC = 3'h4;

  // ****************************************************************
  // sample timing
  // ****************************************************************
  localparam int unsigned FCTM_CLOCK_PERIOD_NS = 20;
  localparam int unsigned FCTM_NARROW_PERIOD_NS = 1000;
  localparam int unsigned FCTM_WIDE_PERIOD_NS = 2000;
  localparam int unsigned FCTM_NARROW_CYCLES = FCTM_NARROW_PERIOD_NS / FCTM_CLOCK_PERIOD_NS;
  localparam int unsigned FCTM_WIDE_CYCLES = FCTM_WIDE_PERIOD_NS / FCTM_CLOCK_PERIOD_NS;
  localparam int unsigned FCTM_TIMER_WIDTH = 8;

  // coefficients as the filter logic sees them, high byte on top
  typedef struct packed {
    logic [7:0] bandpass_a2_low_byte;
    logic [15:0] bandpass_a3;
    logic [15:0] bandpass_b1;
    logic [14:0] lowpass_a2;
    logic [14:0] lowpass_b1;
  } fctm_coeff_t;

endpackage
`default_nettype wire

// ### verilog/fctm_sample_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// sample strobe divider
// ****************************************************************
module fctm_sample_timer #(
  parameter int unsigned NARROW_CYCLES = fctm_pkg::FCTM_NARROW_CYCLES,
  parameter int unsigned WIDE_CYCLES = fctm_pkg::FCTM_WIDE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic wide,
  output logic strobe
);

  localparam int unsigned W = fctm_pkg::FCTM_TIMER_WIDTH;
  localparam logic [W-1:0] NARROW_LAST = W'(NARROW_CYCLES - 1);
  localparam logic [W-1:0] WIDE_LAST = W'(WIDE_CYCLES - 1);

  logic [W-1:0] count;
  wire logic [W-1:0] last = wide ? WIDE_LAST : NARROW_LAST;
  // a switch to the shorter period mid-count wraps at once, never overruns
  wire logic at_end = (count >= last);
  wire logic [W-1:0] next_count = (!run || at_end) ? '0 : count + W'(1);

  // count stays at zero while idle so the first sample is a full period away
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      strobe <= 1'b0;
    end
    else
    begin
      count <= next_count;
      strobe <= run && at_end;
    end
  end

  a_idle_no_strobe: assert property (@(posedge clock) disable iff (!rst_n)
    !run |=> !strobe) else $error("sample strobe while timer idle");

  a_strobe_single_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    strobe |=> !strobe) else $error("sample strobe longer than one cycle");

endmodule
`default_nettype wire

// ### verilog/fctm_regs.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// filter coefficient and test select register bank
// ****************************************************************
module fctm_regs (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_address,
  input wire logic [7:0] reg_write_data,
  input wire logic reg_write_strobe,
  input wire logic reg_read_strobe,
  output logic [7:0] reg_read_data,
  input wire logic osc_8mhz_pin,
  input wire logic adc_sample_clock_pin,
  output fctm_pkg::fctm_coeff_t coefficients,
  output logic test_pin_level,
  output logic test_pin_output_enable,
  output logic test_analog_route_enable,
  output logic [2:0] datapath_tap_source,
  output logic datapath_sample_wide,
  output logic datapath_sample_strobe
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] reset_pipe;
  wire logic rst_n = reset_pipe[1];

  // release is synchronous so no flop sees a half-released reset
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      reset_pipe <= 2'h0;
    else
      reset_pipe <= {reset_pipe[0], 1'b1};
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  localparam int unsigned N = fctm_pkg::FCTM_REG_COUNT;

  logic [7:0] bank [N];

  wire logic in_range = (reg_address >= fctm_pkg::FCTM_ADDR_FIRST)
    && (reg_address <= fctm_pkg::FCTM_ADDR_LAST);
  wire logic [7:0] offset = reg_address - fctm_pkg::FCTM_ADDR_FIRST;
  wire logic [3:0] index = offset[3:0];
  wire logic [7:0] read_word = in_range ? bank[index] : fctm_pkg::FCTM_UNMAPPED_READ;

  // ****************************************************************
  // register storage
  // ****************************************************************
  // one writable byte per entry; masked bits never store, so they read zero
  generate
    for (genvar i = 0; i < N; i++)
    begin : g_entry
      wire logic hit = reg_write_strobe && in_range && (index == 4'(i));
      wire logic [7:0] mask = fctm_pkg::FCTM_WRITE_MASK[i];
      wire logic [7:0] next_value = hit ? (reg_write_data & mask) : bank[i];

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          bank[i] <= fctm_pkg::FCTM_RESET_VALUE;
        else
          bank[i] <= next_value;
      end
    end
  endgenerate

  // read answer lands in the cycle after the strobe and only there
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_read_data <= 8'h00;
    else
      reg_read_data <= reg_read_strobe ? read_word : 8'h00;
  end

  // ****************************************************************
  // coefficients to the filters
  // ****************************************************************
  // lowpass high bytes contribute only their seven stored bits
  assign coefficients.bandpass_a2_low_byte = bank[fctm_pkg::FCTM_IDX_BANDPASS_A2_LOW];
  assign coefficients.bandpass_a3 = {bank[fctm_pkg::FCTM_IDX_BANDPASS_A3_HIGH],
    bank[fctm_pkg::FCTM_IDX_BANDPASS_A3_LOW]};
  assign coefficients.bandpass_b1 = {bank[fctm_pkg::FCTM_IDX_BANDPASS_B1_HIGH],
    bank[fctm_pkg::FCTM_IDX_BANDPASS_B1_LOW]};
  assign coefficients.lowpass_a2 = {bank[fctm_pkg::FCTM_IDX_LOWPASS_A2_HIGH][6:0],
    bank[fctm_pkg::FCTM_IDX_LOWPASS_A2_LOW]};
  assign coefficients.lowpass_b1 = {bank[fctm_pkg::FCTM_IDX_LOWPASS_B1_HIGH][6:0],
    bank[fctm_pkg::FCTM_IDX_LOWPASS_B1_LOW]};

  // ****************************************************************
  // test select fields
  // ****************************************************************
  wire logic [7:0] test_word = bank[fctm_pkg::FCTM_IDX_TEST_AND_DATAPATH];
  wire logic [2:0] test_select =
    test_word[fctm_pkg::FCTM_TEST_SEL_MSB:fctm_pkg::FCTM_TEST_SEL_LSB];
  wire logic sample_wide_select = test_word[fctm_pkg::FCTM_SAMPLE_FMT_BIT];
  wire logic [2:0] source_select =
    test_word[fctm_pkg::FCTM_DP_SEL_MSB:fctm_pkg::FCTM_DP_SEL_LSB];

  // ****************************************************************
  // pin inputs
  // ****************************************************************
  // bit 1 is the 8 MHz oscillator, bit 0 the ADC sample clock
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_late;
  logic [1:0] pin_level;
  wire logic [1:0] pins = {osc_8mhz_pin, adc_sample_clock_pin};
  // a bit moves only when the last two stages agree, otherwise it holds
  wire logic [1:0] next_pin_level = (pin_sync & pin_late)
    | (pin_level & (pin_sync | pin_late));

  // an 8 MHz clock seen at 50 MHz comes out with a cycle of jitter;
  // good enough for a scope on the test pin, not for timing anything
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_late <= 2'h0;
      pin_level <= 2'h0;
    end
    else
    begin
      pin_meta <= pins;
      pin_sync <= pin_meta;
      pin_late <= pin_sync;
      pin_level <= next_pin_level;
    end
  end

  // ****************************************************************
  // test pin drive
  // ****************************************************************
  // reserved codes 2 and 3 leave both the digital driver and the analog switch off; 6 and 7 turn the driver on at level zero
  wire logic next_test_level = (test_select == fctm_pkg::FCTM_TEST_OSC_8MHZ) ? pin_level[1]
    : (test_select == fctm_pkg::FCTM_TEST_ADC_CLOCK) ? pin_level[0] : 1'b0;
  wire logic next_test_digital = test_select[2];
  wire logic next_test_analog = (test_select == fctm_pkg::FCTM_TEST_FRONT_END);

  // ****************************************************************
  // data-path tap
  // ****************************************************************
  // source codes 5 to 7 behave as disabled, 2 and 3 pass as live taps; the format bit counts only with a live tap
  wire logic tap_active = (source_select >= fctm_pkg::FCTM_DP_LOWPASS)
    && (source_select <= fctm_pkg::FCTM_DP_ADC);
  wire logic [2:0] next_tap_source = tap_active ? source_select : fctm_pkg::FCTM_DP_OFF;
  wire logic next_sample_wide = tap_active && sample_wide_select;

  // every pin-facing output leaves from a flop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      test_pin_level <= 1'b0;
      test_pin_output_enable <= 1'b0;
      test_analog_route_enable <= 1'b0;
      datapath_tap_source <= fctm_pkg::FCTM_DP_OFF;
      datapath_sample_wide <= 1'b0;
    end
    else
    begin
      test_pin_level <= next_test_level;
      test_pin_output_enable <= next_test_digital;
      test_analog_route_enable <= next_test_analog;
      datapath_tap_source <= next_tap_source;
      datapath_sample_wide <= next_sample_wide;
    end
  end

  // sample cadence: 50 cycles narrow, 100 cycles wide
  fctm_sample_timer #(
    .NARROW_CYCLES(fctm_pkg::FCTM_NARROW_CYCLES),
    .WIDE_CYCLES(fctm_pkg::FCTM_WIDE_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .run(tap_active),
    .wide(next_sample_wide),
    .strobe(datapath_sample_strobe)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  // cycles since the last strobe, trusted only while the setting held still
  logic [7:0] gap_count;
  logic gap_valid;
  logic gap_wide;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_count <= 8'h00;
      gap_valid <= 1'b0;
      gap_wide <= 1'b0;
    end
    else
    begin
      gap_count <= datapath_sample_strobe ? 8'h01 : gap_count + 8'h01;
      gap_wide <= next_sample_wide;
      if (!tap_active || (next_sample_wide != gap_wide))
        gap_valid <= 1'b0;
      else if (datapath_sample_strobe)
        gap_valid <= 1'b1;
    end
  end

  a_bandpass_a3_readback: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write_strobe && reg_address == fctm_pkg::FCTM_ADDR_BANDPASS_A3_HIGH
    ##1 reg_read_strobe && reg_address == fctm_pkg::FCTM_ADDR_BANDPASS_A3_HIGH
    |=> reg_read_data == $past(reg_write_data, 2)) else $error("a3 high readback wrong");

  a_bandpass_a2_store: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write_strobe && reg_address == fctm_pkg::FCTM_ADDR_BANDPASS_A2_LOW
    |=> coefficients.bandpass_a2_low_byte == $past(reg_write_data))
    else $error("a2 low byte not stored");

  a_lowpass_a2_reserved: assert property (@(posedge clock) disable iff (!rst_n)
    reg_read_strobe && reg_address == fctm_pkg::FCTM_ADDR_LOWPASS_A2_HIGH
    |=> !reg_read_data[7]) else $error("lowpass a2 reserved bit set");

  a_lowpass_b1_reserved: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write_strobe && reg_address == fctm_pkg::FCTM_ADDR_LOWPASS_B1_HIGH
    ##1 reg_read_strobe && reg_address == fctm_pkg::FCTM_ADDR_LOWPASS_B1_HIGH
    |=> reg_read_data == {1'b0, $past(reg_write_data[6:0], 2)})
    else $error("lowpass b1 high readback wrong");

  a_lowpass_low_store: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write_strobe && reg_address == fctm_pkg::FCTM_ADDR_LOWPASS_A2_LOW
    |=> coefficients.lowpass_a2[7:0] == $past(reg_write_data))
    else $error("lowpass a2 low byte not stored");

  a_test_pin_route: assert property (@(posedge clock) disable iff (!rst_n)
    test_select == fctm_pkg::FCTM_TEST_ADC_CLOCK
    |=> test_pin_level == $past(pin_level[0]) && test_pin_output_enable
    && !test_analog_route_enable) else $error("adc clock not on test pin");

  a_test_pin_class: assert property (@(posedge clock) disable iff (!rst_n)
    !test_select[2] |=> !test_pin_output_enable && !test_pin_level)
    else $error("analog code drives digital pin");

  a_sample_spacing: assert property (@(posedge clock) disable iff (!rst_n)
    datapath_sample_strobe && gap_valid
    |-> gap_count == (gap_wide ? 8'(fctm_pkg::FCTM_WIDE_CYCLES)
    : 8'(fctm_pkg::FCTM_NARROW_CYCLES))) else $error("sample spacing wrong");

  a_format_needs_tap: assert property (@(posedge clock) disable iff (!rst_n)
    !tap_active |=> !datapath_sample_wide ##1 !datapath_sample_strobe)
    else $error("sample format active without tap");

  a_tap_source: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> datapath_tap_source == ($past(tap_active) ? $past(source_select)
    : fctm_pkg::FCTM_DP_OFF)) else $error("tap source mismatch");

  a_reset_defaults: assert property (@(posedge clock)
    $rose(rst_n) |-> test_word == 8'h00 && !test_pin_output_enable
    && datapath_tap_source == fctm_pkg::FCTM_DP_OFF && !datapath_sample_wide)
    else $error("test select not clear after reset");

  a_coeff_high_order: assert property (@(posedge clock) disable iff (!rst_n)
    reg_write_strobe && reg_address == fctm_pkg::FCTM_ADDR_BANDPASS_B1_HIGH
    |=> coefficients.bandpass_b1[15:8] == $past(reg_write_data))
    else $error("b1 high byte not on top");

endmodule
`default_nettype wire

// ### verif/tb_filter_coeff_test_mux_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_filter_coeff_test_mux_regs;
  logic clock;
  logic reset_n;
  logic [7:0] reg_address;
  logic [7:0] reg_write_data;
  logic reg_write_strobe;
  logic reg_read_strobe;
  logic [7:0] reg_read_data;
  logic osc_8mhz_pin;
  logic adc_sample_clock_pin;
  fctm_pkg::fctm_coeff_t coefficients;
  logic test_pin_level;
  logic test_pin_output_enable;
  logic test_analog_route_enable;
  logic [2:0] datapath_tap_source;
  logic datapath_sample_wide;
  logic datapath_sample_strobe;
  int n_mismatch;
  int num_checks;
  int cycle_count;
  int period;
  logic [7:0] rd;
  logic exp_level;
  // expected map: address, writable bits, pattern written in the coefficient test
  logic [7:0] addr_tab [10] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49,
                                8'h4a, 8'h4b};
  logic [7:0] mask_tab [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'h7f,
                                8'hff, 8'hef};
  logic [7:0] val_tab [10] = '{8'h9a, 8'h12, 8'h34, 8'h56, 8'h78, 8'hbc, 8'hde, 8'hf1,
                               8'h23, 8'h00};

  fctm_regs dut_u (
    .clock(clock),
    .reset_n(reset_n),
    .reg_address(reg_address),
    .reg_write_data(reg_write_data),
    .reg_write_strobe(reg_write_strobe),
    .reg_read_strobe(reg_read_strobe),
    .reg_read_data(reg_read_data),
    .osc_8mhz_pin(osc_8mhz_pin),
    .adc_sample_clock_pin(adc_sample_clock_pin),
    .coefficients(coefficients),
    .test_pin_level(test_pin_level),
    .test_pin_output_enable(test_pin_output_enable),
    .test_analog_route_enable(test_analog_route_enable),
    .datapath_tap_source(datapath_tap_source),
    .datapath_sample_wide(datapath_sample_wide),
    .datapath_sample_strobe(datapath_sample_strobe)
  );

  // ****************************************************************
  // clock and hang guard
  // ****************************************************************
  initial clock = 1'b0;
  always #10 clock = ~clock;

  // ceiling is several times the expected run, so only a real hang trips it
  always @(posedge clock)
  begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 8000)
    begin
      n_mismatch++;
      $display("BAD timeout expected done seen hang");
      test_done();
    end
  end

  // ****************************************************************
  // bus tasks and compare
  // ****************************************************************
  // each bus task ends 1 ns after the taking edge so outputs have settled
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_address <= a;
    reg_write_data <= d;
    reg_write_strobe <= 1'b1;
    @(posedge clock);
    reg_write_strobe <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe, so it is taken there
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_address <= a;
    reg_read_strobe <= 1'b1;
    @(posedge clock);
    reg_read_strobe <= 1'b0;
    #1;
    d = reg_read_data;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait for one strobe, then count cycles to the next one
  task automatic strobe_gap(output int n);
    int k;
    k = 0;
    while (datapath_sample_strobe !== 1'b1 && k < 300)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (datapath_sample_strobe !== 1'b1 && n < 300);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    cycle_count = 0;
    reset_n = 1'b0;
    reg_address = 8'h00;
    reg_write_data = 8'h00;
    reg_write_strobe = 1'b0;
    reg_read_strobe = 1'b0;
    osc_8mhz_pin = 1'b0;
    adc_sample_clock_pin = 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);

    // reset values of every register and of the coefficient, output-enable, tap and format outputs
    for (int i = 0; i < 10; i++)
    begin
      reg_read(addr_tab[i], rd);
      check("reset_read", 16'h0000, 16'(rd));
    end
    check("reset_coeff", 16'h0001, 16'(coefficients === '0));
    check("reset_oe", 16'h0000, 16'(test_pin_output_enable));
    check("reset_tap", 16'h0000, 16'(datapath_tap_source));
    check("reset_wide", 16'h0000, 16'(datapath_sample_wide));
    $display("test reset_values done");

    // all ones shows the writable bits; reserved bits read zero
    for (int i = 0; i < 10; i++)
    begin
      reg_write(addr_tab[i], 8'hff);
      reg_read(addr_tab[i], rd);
      check("mask_read", 16'(mask_tab[i]), 16'(rd));
    end
    for (int i = 0; i < 10; i++)
      reg_write(addr_tab[i], val_tab[i]);
    for (int i = 0; i < 10; i++)
    begin
      reg_read(addr_tab[i], rd);
      check("pattern_read", 16'(val_tab[i] & mask_tab[i]), 16'(rd));
    end
    check("bp_a2_low", 16'h009a, 16'(coefficients.bandpass_a2_low_byte));
    check("bp_a3", 16'h1234, coefficients.bandpass_a3);
    check("bp_b1", 16'h5678, coefficients.bandpass_b1);
    check("lp_a2", 16'h3cde, 16'(coefficients.lowpass_a2));
    check("lp_b1", 16'h7123, 16'(coefficients.lowpass_b1));
    $display("test coefficient_bytes done");

    // unmapped neighbours neither store nor disturb the bank
    reg_write(8'h41, 8'hff);
    reg_write(8'h4c, 8'hff);
    reg_read(8'h4c, rd);
    check("unmapped_read", 16'h0000, 16'(rd));
    reg_read(8'h42, rd);
    check("neighbour_read", 16'h009a, 16'(rd));
    @(posedge clock);
    #1;
    check("idle_read_data", 16'h0000, 16'(reg_read_data));
    $display("test unmapped done");

    // every test pin code, with the two pin inputs in both phases
    for (int p = 0; p < 2; p++)
    begin
      osc_8mhz_pin <= (p == 0);
      adc_sample_clock_pin <= (p != 0);
      for (int c = 0; c < 8; c++)
      begin
        reg_write(8'h4b, {3'(c), 5'h00});
        repeat (8) @(posedge clock);
        #1;
        exp_level = (c == 4) ? (p == 0) : ((c == 5) ? (p != 0) : 1'b0);
        check("pin_oe", 16'(c >= 4), 16'(test_pin_output_enable));
        check("pin_analog", 16'(c == 1), 16'(test_analog_route_enable));
        check("pin_level", 16'(exp_level), 16'(test_pin_level));
      end
    end
    $display("test test_pin done");

    // every source code with both sample formats
    for (int c = 0; c < 8; c++)
      for (int w = 0; w < 2; w++)
      begin
        reg_write(8'h4b, {4'h0, 1'(w), 3'(c)});
        // tap outputs leave a flop fed by the bank, one edge after the write lands
        @(posedge clock);
        #1;
        check("tap_source", 16'((c >= 1 && c <= 4) ? c : 0), 16'(datapath_tap_source));
        check("sample_wide", 16'(w == 1 && c >= 1 && c <= 4), 16'(datapath_sample_wide));
        reg_read(8'h4b, rd);
        check("select_read", 16'({w[0], 3'(c)}), 16'(rd));
      end
    $display("test datapath_select done");

    // sample period: 1 us is 50 cycles, 2 us is 100 cycles at 50 MHz
    reg_write(8'h4b, 8'h01);
    strobe_gap(period);
    check("narrow_period", 16'd50, 16'(period));
    reg_write(8'h4b, 8'h09);
    strobe_gap(period);
    strobe_gap(period);
    check("wide_period", 16'd100, 16'(period));
    reg_write(8'h4b, 8'h0d);
    strobe_gap(period);
    check("no_strobe_unused", 16'd300, 16'(period));
    $display("test sample_period done");

    // write then read with no gap, the tightest legal spacing
    @(posedge clock);
    reg_address <= 8'h43;
    reg_write_data <= 8'ha5;
    reg_write_strobe <= 1'b1;
    @(posedge clock);
    reg_write_strobe <= 1'b0;
    reg_read_strobe <= 1'b1;
    @(posedge clock);
    reg_read_strobe <= 1'b0;
    #1;
    check("back_to_back", 16'h00a5, 16'(reg_read_data));
    $display("test back_to_back done");

    // reset in mid-run clears the bank again
    reg_write(8'h43, 8'h55);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("midreset_coeff", 16'h0001, 16'(coefficients === '0));
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    reg_read(8'h43, rd);
    check("midreset_read", 16'h0000, 16'(rd));
    reg_read(8'h4b, rd);
    check("midreset_select", 16'h0000, 16'(rd));
    $display("test midrun_reset done");
    test_done();
  end
endmodule

`default_nettype wire
